// [verilog/txfc_pkg.sv]
// package: constants and types for the transmit frame-control block
package txfc_pkg;
  // ==========================================================
  // register map (apb byte addresses)
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] LENGTH_OFS = 12'h008;
  localparam logic [21:0] CTRL_RST   = 22'h000000;

  // ==========================================================
  // frame-control word fields
  localparam int FID_LSB   = 0;   // frame_identifier 15:0
  localparam int ALIGN_LSB = 16;  // length_alignment_select 17:16
  localparam int TCP_BIT   = 18;  // tcp_csum_request
  localparam int UDP_BIT   = 19;  // udp_csum_request
  localparam int IP_BIT    = 20;  // ip_csum_request
  localparam int FCS_BIT   = 21;  // fcs_append_inhibit
  localparam int CTRL_W    = 22;

  // ==========================================================
  // frame layout (byte offsets in the ethernet frame or in the transport header, and fcs size)
  localparam logic [15:0] IP_HDR_POS   = 16'h000E;
  localparam logic [15:0] IP_LEN_HI    = 16'h0010;
  localparam logic [15:0] IP_LEN_LO    = 16'h0011;
  localparam logic [15:0] IP_PROTO_POS = 16'h0017;
  localparam logic [15:0] IP_CK_POS    = 16'h0018;
  localparam logic [15:0] IP_SRC_POS   = 16'h001A;
  localparam logic [15:0] IP_ADDR_END  = 16'h0022;
  localparam logic [15:0] TCP_CK_OFS   = 16'h0010;
  localparam logic [15:0] UDP_CK_OFS   = 16'h0006;
  localparam logic [15:0] FCS_BYTES    = 16'h0004;

  // ==========================================================
  // frame store and fcs
  localparam int          FRAME_AW  = 11;
  localparam logic [15:0] FRAME_MAX = 16'h0800;
  localparam logic [31:0] CRC_INIT  = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY  = 32'hEDB88320;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOAD = 4'h2,
    ST_FIN  = 4'h4,
    ST_SEND = 4'h8
  } state_t;
endpackage

// [verilog/fcs_crc32_byte.sv]
// module: one-byte step of the ethernet crc32, lsb first
`timescale 1ns/1ps
module fcs_crc32_byte (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_out
);
  // ==========================================================
  // bitwise reflected crc over eight data bits
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ txfc_pkg::CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end
endmodule

// [verilog/tx_frame_control.sv]
// module: frame-control word interpreter with checksum, padding and fcs
`timescale 1ns/1ps

module tx_frame_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_valid,
  input  wire logic        in_last,
  output logic             in_ready,
  output logic      [7:0]  out_data,
  output logic             out_valid,
  output logic             out_last,
  output logic      [15:0] out_frame_id,
  input  wire logic        out_ready
);
  // ==========================================================
  // state
  typedef struct packed {
    txfc_pkg::state_t st;
    logic [21:0]      ctrl;
    logic [21:0]      fc;
    logic [15:0]      idx;
    logic [15:0]      len;
    logic [15:0]      plen;
    logic [15:0]      tot;
    logic [5:0]       ihlb;
    logic [7:0]       proto;
    logic [31:0]      ip_sum;
    logic [31:0]      l4_sum;
    logic [15:0]      ip_ck;
    logic [15:0]      l4_ck;
    logic [31:0]      crc;
    logic [15:0]      last_id;
    logic [15:0]      last_len;
    logic [7:0]       od;
    logic             ov;
    logic             ol;
    logic [15:0]      oid;
  } regs_t;

  regs_t       s_r;
  regs_t       s_nxt;
  logic [7:0]  mem [0:(1 << txfc_pkg::FRAME_AW) - 1];
  logic [7:0]  send_byte;
  logic [31:0] crc_step;
  logic        fcs_on;
  logic        l4_req;
  logic [15:0] frame_total;
  logic        in_fire;

  // ==========================================================
  // helpers
  // add a byte to a ones-complement sum at its word half
  function automatic logic [31:0] add_byte(input logic [31:0] sum,
                                           input logic [15:0] pos,
                                           input logic [7:0]  b);
    if (pos[0]) begin
      add_byte = sum + {24'h000000, b};
    end else begin
      add_byte = sum + {16'h0000, b, 8'h00};
    end
  endfunction

  // fold a 32-bit sum to 16 bits with end-around carry
  function automatic logic [15:0] fold16(input logic [31:0] sum);
    logic [16:0] f;
    f = {1'b0, sum[15:0]} + {1'b0, sum[31:16]};
    f = {1'b0, f[15:0]} + {16'h0000, f[16]};
    fold16 = f[15:0];
  endfunction

  // byte position of the transport checksum field
  function automatic logic [15:0] l4_pos(input logic [5:0] ihlb,
                                         input logic       tcp);
    l4_pos = txfc_pkg::IP_HDR_POS + {10'h000, ihlb}
           + (tcp ? txfc_pkg::TCP_CK_OFS : txfc_pkg::UDP_CK_OFS);
  endfunction

  // length after rounding to the selected boundary
  function automatic logic [15:0] align_len(input logic [15:0] len,
                                            input logic [1:0]  sel);
    if (sel[0]) begin
      align_len = len;
    end else if (sel[1]) begin
      align_len = (len + 16'h0001) & 16'hFFFE;
    end else begin
      align_len = (len + 16'h0003) & 16'hFFFC;
    end
  endfunction

  // ==========================================================
  // shared terms
  // checksum forces fcs
  assign fcs_on = ~s_r.fc[txfc_pkg::FCS_BIT]
                | s_r.fc[txfc_pkg::TCP_BIT]
                | s_r.fc[txfc_pkg::UDP_BIT]
                | s_r.fc[txfc_pkg::IP_BIT];
  assign l4_req = s_r.fc[txfc_pkg::TCP_BIT] | s_r.fc[txfc_pkg::UDP_BIT];
  assign frame_total = s_r.plen + (fcs_on ? txfc_pkg::FCS_BYTES : 16'h0000);
  assign in_ready    = (s_r.st == txfc_pkg::ST_LOAD);
  assign in_fire     = in_ready & in_valid;

  // outgoing byte: stored data, inserted checksums, pad, then fcs
  always_comb begin
    logic [15:0] k;
    logic [15:0] cp;
    k  = s_r.idx - s_r.plen;
    cp = l4_pos(s_r.ihlb, s_r.fc[txfc_pkg::TCP_BIT]);
    send_byte = 8'h00;
    if (s_r.idx < s_r.len) begin
      send_byte = mem[s_r.idx[txfc_pkg::FRAME_AW-1:0]];
      if (s_r.fc[txfc_pkg::IP_BIT] && s_r.idx == txfc_pkg::IP_CK_POS) begin
        send_byte = s_r.ip_ck[15:8];
      end
      if (s_r.fc[txfc_pkg::IP_BIT] &&
          s_r.idx == txfc_pkg::IP_CK_POS + 16'h0001) begin
        send_byte = s_r.ip_ck[7:0];
      end
      if (l4_req && s_r.idx == cp) begin
        send_byte = s_r.l4_ck[15:8];
      end
      if (l4_req && s_r.idx == cp + 16'h0001) begin
        send_byte = s_r.l4_ck[7:0];
      end
    end else if (s_r.idx < s_r.plen) begin
      send_byte = 8'h00;
    end else begin
      send_byte = ~s_r.crc[{k[1:0], 3'b000} +: 8];
    end
  end

  fcs_crc32_byte u_crc (
    .crc_in  (s_r.crc),
    .data    (send_byte),
    .crc_out (crc_step)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [15:0] cp;
    logic [15:0] hdr_end;
    logic [15:0] ck;
    s_nxt   = s_r;
    cp      = l4_pos(s_r.ihlb, s_r.fc[txfc_pkg::TCP_BIT]);
    hdr_end = txfc_pkg::IP_HDR_POS + {10'h000, s_r.ihlb};
    ck      = 16'h0000;
    // apb write of the frame-control word
    if (psel && penable && pwrite && paddr == txfc_pkg::CTRL_OFS) begin
      s_nxt.ctrl = pwdata[txfc_pkg::CTRL_W-1:0];
    end
    if (out_ready) begin
      s_nxt.ov = 1'b0;
    end
    case (s_r.st)
      txfc_pkg::ST_IDLE: begin
        if (in_valid) begin
          s_nxt.st     = txfc_pkg::ST_LOAD;
          s_nxt.fc     = s_r.ctrl;
          s_nxt.idx    = 16'h0000;
          s_nxt.ihlb   = 6'h00;
          s_nxt.tot    = 16'h0000;
          s_nxt.proto  = 8'h00;
          s_nxt.ip_sum = 32'h00000000;
          s_nxt.l4_sum = 32'h00000000;
          s_nxt.crc    = txfc_pkg::CRC_INIT;
        end
      end
      txfc_pkg::ST_LOAD: begin
        if (in_valid) begin
          if (s_r.idx == txfc_pkg::IP_HDR_POS) begin
            s_nxt.ihlb = {in_data[3:0], 2'b00};
          end
          if (s_r.idx == txfc_pkg::IP_LEN_HI) begin
            s_nxt.tot[15:8] = in_data;
          end
          if (s_r.idx == txfc_pkg::IP_LEN_LO) begin
            s_nxt.tot[7:0] = in_data;
          end
          if (s_r.idx == txfc_pkg::IP_PROTO_POS) begin
            s_nxt.proto = in_data;
          end
          if (s_r.idx >= txfc_pkg::IP_HDR_POS &&
              (s_r.idx == txfc_pkg::IP_HDR_POS || s_r.idx < hdr_end) &&
              s_r.idx != txfc_pkg::IP_CK_POS &&
              s_r.idx != txfc_pkg::IP_CK_POS + 16'h0001) begin
            s_nxt.ip_sum = add_byte(s_r.ip_sum, s_r.idx, in_data);
          end
          if (s_r.idx >= txfc_pkg::IP_SRC_POS &&
              s_r.idx < txfc_pkg::IP_ADDR_END) begin
            s_nxt.l4_sum = add_byte(s_r.l4_sum, s_r.idx, in_data);
          end
          if (s_r.idx > txfc_pkg::IP_HDR_POS && s_r.idx >= hdr_end &&
              s_r.idx < txfc_pkg::IP_HDR_POS + s_r.tot &&
              s_r.idx != cp && s_r.idx != cp + 16'h0001) begin
            s_nxt.l4_sum = add_byte(s_r.l4_sum, s_r.idx, in_data);
          end
          s_nxt.idx = s_r.idx + 16'h0001;
          if (in_last) begin
            s_nxt.len = (s_r.idx < txfc_pkg::FRAME_MAX)
                      ? s_r.idx + 16'h0001 : txfc_pkg::FRAME_MAX;
            s_nxt.st  = txfc_pkg::ST_FIN;
          end
        end
      end
      txfc_pkg::ST_FIN: begin
        s_nxt.ip_ck = ~fold16(s_r.ip_sum);
        // add protocol and segment length, then complement
        ck = ~fold16(s_r.l4_sum + {24'h000000, s_r.proto}
                     + {16'h0000, s_r.tot - {10'h000, s_r.ihlb}});
        if (!s_r.fc[txfc_pkg::TCP_BIT] && ck == 16'h0000) begin
          ck = 16'hFFFF;
        end
        s_nxt.l4_ck = ck;
        s_nxt.plen = align_len(s_r.len, s_r.fc[txfc_pkg::ALIGN_LSB +: 2]);
        s_nxt.idx  = 16'h0000;
        s_nxt.st   = txfc_pkg::ST_SEND;
      end
      txfc_pkg::ST_SEND: begin
        if (!s_r.ov || out_ready) begin
          s_nxt.od  = send_byte;
          s_nxt.ov  = 1'b1;
          s_nxt.oid = s_r.fc[txfc_pkg::FID_LSB +: 16];
          s_nxt.ol  = (s_r.idx == frame_total - 16'h0001);
          if (s_r.idx < s_r.plen) begin
            s_nxt.crc = crc_step;
          end
          s_nxt.idx = s_r.idx + 16'h0001;
          if (s_r.idx == frame_total - 16'h0001) begin
            s_nxt.st       = txfc_pkg::ST_IDLE;
            s_nxt.last_id  = s_r.fc[txfc_pkg::FID_LSB +: 16];
            s_nxt.last_len = frame_total;
          end
        end
      end
      default: begin
        s_nxt.st = txfc_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r      <= '0;
      s_r.st   <= txfc_pkg::ST_IDLE;
      s_r.ctrl <= txfc_pkg::CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // frame store; bytes past the store are dropped
  always_ff @(posedge pclk) begin
    if (in_fire && s_r.idx < txfc_pkg::FRAME_MAX) begin
      mem[s_r.idx[txfc_pkg::FRAME_AW-1:0]] <= in_data;
    end
  end

  // ==========================================================
  // outputs and apb read
  assign out_data     = s_r.od;
  assign out_valid    = s_r.ov;
  assign out_last     = s_r.ol;
  assign out_frame_id = s_r.oid;
  assign pready       = 1'b1;

  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      txfc_pkg::CTRL_OFS:   prdata = {10'h000, s_r.ctrl};
      txfc_pkg::STATUS_OFS: prdata = {s_r.last_id, 15'h0000,
                                      s_r.st != txfc_pkg::ST_IDLE};
      txfc_pkg::LENGTH_OFS: prdata = {16'h0000, s_r.last_len};
      default:              pslverr = psel & penable;
    endcase
  end
endmodule

// [sim/tx_frame_control_assertions.sv]
// checker: frame length, fcs and identifier relations at the ports
`timescale 1ns/1ps
module tx_frame_control_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        in_last,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        out_last,
  input wire logic [15:0] out_frame_id
);
  logic [21:0] ctl_r;
  logic [15:0] in_n, out_n, len_r, pad, tot;
  logic        fin, fcs;
  // ==========================================
  // shadow of control word and byte counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 22'h000000;
      in_n <= 16'h0000;
      out_n <= 16'h0000;
      len_r <= 16'h0000;
    end else begin
      if (penable && pwrite && paddr == txfc_pkg::CTRL_OFS)
        ctl_r <= pwdata[21:0];
      if (in_valid && in_ready)
        in_n <= in_last ? 16'h0000 : in_n + 16'h0001;
      if (in_valid && in_ready && in_last)
        len_r <= in_n + 16'h0001;
      if (out_valid && out_ready)
        out_n <= out_last ? 16'h0000 : out_n + 16'h0001;
    end
  end
  // expected frame size from the shadowed control word
  assign fin = out_valid && out_ready && out_last;
  assign fcs = !ctl_r[21] || (ctl_r[20:18] != 3'h0);
  assign pad = ctl_r[16] ? len_r : ctl_r[17] ? (len_r + 16'h0001) & 16'hFFFE
                                            : (len_r + 16'h0003) & 16'hFFFC;
  assign tot = pad + (fcs ? 16'h0004 : 16'h0000);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // properties
  property p_len_dword;
    fin && ctl_r[17:16] == 2'h0 |-> out_n + 16'h0001 == tot;
  endproperty
  a_len_dword: assert property (p_len_dword) else $error("dword size");
  property p_len_word;
    fin && ctl_r[17:16] == 2'h2 |-> out_n + 16'h0001 == tot;
  endproperty
  a_len_word: assert property (p_len_word) else $error("word size");
  property p_len_none;
    fin && ctl_r[16] |-> out_n + 16'h0001 == tot;
  endproperty
  a_len_none: assert property (p_len_none) else $error("raw size");
  property p_fcs_forced;
    fin && ctl_r[20:18] != 3'h0 |-> out_n + 16'h0001 == pad + 16'h0004;
  endproperty
  a_fcs_forced: assert property (p_fcs_forced) else $error("no fcs");
  property p_fcs_off;
    fin && ctl_r[21:18] == 4'h8 |-> out_n + 16'h0001 == pad;
  endproperty
  a_fcs_off: assert property (p_fcs_off) else $error("fcs added");
  property p_id;
    out_valid |-> out_frame_id == ctl_r[15:0];
  endproperty
  a_id: assert property (p_id) else $error("frame id wrong");
  property p_no_load;
    out_valid |-> !in_ready;
  endproperty
  a_no_load: assert property (p_no_load) else $error("load in send");
  property p_emit;
    in_valid && in_ready && in_last |-> ##[2:6] out_valid;
  endproperty
  a_emit: assert property (p_emit) else $error("frame not sent");
  c_tcp: cover property (fin && ctl_r[18]);
  c_udp: cover property (fin && ctl_r[19]);
  c_word: cover property (fin && ctl_r[17:16] == 2'h2);
endmodule
bind tx_frame_control tx_frame_control_chk chk_u (.pclk(pclk),
  .presetn(presetn), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .in_valid(in_valid), .in_ready(in_ready),
  .in_last(in_last), .out_valid(out_valid), .out_ready(out_ready),
  .out_last(out_last), .out_frame_id(out_frame_id));

// [sim/host_model.sv]
// partner model: host memory streaming one frame into the block
`timescale 1ns/1ps
module host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [15:0] len,
  input  wire logic        in_ready,
  output logic      [7:0]  in_data,
  output logic             in_valid,
  output logic             in_last
);
  logic [7:0]  mem [0:2047];
  logic [15:0] idx;
  logic        gap;
  logic [7:0]  tick;
  initial begin
    for (int k = 0; k < 2048; k++)
      mem[k] = 8'(k * 29 + 5);
    mem[12] = 8'h08;
    mem[13] = 8'h00;
    mem[14] = 8'h45;
  end
  // idle data changes every cycle, never the last byte
  assign in_data = in_valid ? mem[idx[10:0]] : tick;
  assign in_last = in_valid && idx == len - 16'h0001;
  // hold each byte until taken; slow mode leaves a gap after each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 16'h0000;
      in_valid <= 1'b0;
      gap <= 1'b0;
      tick <= 8'h00;
    end else begin
      tick <= tick + 8'h35;
      if (go) begin
        idx <= 16'h0000;
        in_valid <= 1'b1;
      end else if (in_valid && in_ready) begin
        idx <= idx + 16'h0001;
        in_valid <= !in_last && !slow;
        gap <= !in_last && slow;
      end else if (gap) begin
        in_valid <= 1'b1;
        gap <= 1'b0;
      end
    end
  end
endmodule

// [sim/tb.sv]
// testbench: frame-control block over apb and byte streams
`timescale 1ns/1ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  in_data, out_data;
  logic        in_valid, in_last, in_ready, out_valid, out_last, out_ready;
  logic [15:0] out_frame_id, n;
  logic        go, slow, perr;
  logic [7:0]  ex [0:127];
  int          err_count, num_checks, cyc, got;
  tx_frame_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_data(in_data),
    .in_valid(in_valid), .in_last(in_last), .in_ready(in_ready),
    .out_data(out_data), .out_valid(out_valid), .out_last(out_last),
    .out_frame_id(out_frame_id), .out_ready(out_ready));
  host_model m_u (.pclk(pclk), .presetn(presetn), .go(go), .slow(slow),
    .len(n), .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid),
    .in_last(in_last));
  // ==========================================
  // helpers
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(logic [31:0] a, logic [31:0] b, string m);
    num_checks++;
    if (a !== b) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, a, b);
    end
  endtask
  // one apb transfer; waits for pready, the global timeout ends a hang
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] fold(int lo, int hi, logic [31:0] s);
    for (int i = lo; i < hi; i += 2)
      s += {ex[i], (i + 1 < hi) ? ex[i + 1] : 8'h00};
    while (s[31:16] != 16'h0000)
      s = s[15:0] + s[31:16];
    return s[15:0];
  endfunction
  task automatic put(int p, logic [15:0] v);
    ex[p] = v[15:8];
    ex[p + 1] = v[7:0];
  endtask
  // send one frame under control word c and compare every byte
  task automatic run(logic [21:0] c, int len, logic [7:0] pr);
    int          k, tot;
    logic [31:0] crc;
    logic [15:0] s;
    logic        last;
    m_u.mem[16] = 8'h00;
    m_u.mem[17] = 8'(len - 14);
    m_u.mem[23] = pr;
    apb(1'b1, txfc_pkg::CTRL_OFS, {10'h000, c});
    for (k = 0; k < 128; k++)
      ex[k] = k < len ? m_u.mem[k] : 8'h00;
    tot = c[16] ? len : c[17] ? (len + 1) / 2 * 2 : (len + 3) / 4 * 4;
    if (c[20]) begin
      put(24, 16'h0000);
      put(24, ~fold(14, 34, 0));
    end
    if (c[19] | c[18]) begin
      k = c[18] ? 50 : 40;
      put(k, 16'h0000);
      s = ~fold(34, len, fold(26, 34, 32'(pr) + len - 34));
      put(k, (s == 16'h0000 && !c[18]) ? 16'hFFFF : s);
    end
    if (!c[21] || c[20:18] != 3'h0) begin
      crc = txfc_pkg::CRC_INIT;
      for (k = 0; k < tot * 8; k++)
        crc = (crc[0] ^ ex[k / 8][k % 8]) ? (crc >> 1) ^ txfc_pkg::CRC_POLY
                                          : crc >> 1;
      for (k = 0; k < 4; k++)
        ex[tot + k] = ~crc[8 * k +: 8];
      tot += 4;
    end
    got = 0;
    last = 1'b0;
    go <= 1'b1;
    n <= 16'(len);
    @(posedge pclk);
    go <= 1'b0;
    while (!last && got < 200) begin
      @(negedge pclk);
      if (out_valid && out_ready) begin
        chk(out_data, ex[got], "byte");
        chk(out_frame_id, c[15:0], "id");
        last = out_last;
        got++;
      end
      @(posedge pclk);
      out_ready <= ~out_ready;
    end
    chk(got, tot, "length");
    apb(1'b0, txfc_pkg::STATUS_OFS, 32'h0);
    chk(rd[31:16], c[15:0], "status id");
    chk({31'h0, rd[0]}, 32'h0, "busy after frame");
    apb(1'b0, txfc_pkg::LENGTH_OFS, 32'h0);
    chk(rd[15:0], tot, "length reg");
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    apb(1'b1, txfc_pkg::CTRL_OFS, 32'hFFFFFFFF);
    apb(1'b0, txfc_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h003FFFFF, "ctrl");
    apb(1'b1, 12'h00C, 32'h1234ABCD);
    chk({31'h0, perr}, 32'h1, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_align;
    for (int i = 0; i < 8; i++)
      run({i[2], 3'h0, i[1:0], 16'hA500 + 16'(i)}, 61, 8'h11);
    $display("test align done");
  endtask
  task automatic t_csum;
    run(22'h180101, 60, 8'h11);
    run(22'h150202, 75, 8'h06);
    slow <= 1'b1;
    run(22'h090303, 57, 8'h11);
    slow <= 1'b0;
    $display("test csum done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, go, slow, out_ready} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    n = 16'h0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_align;
    t_csum;
    print_verdict;
  end
endmodule
